/* logic/tsdma_pkg.sv */
// Package of constants and types for the timestamp double-buffer engine
`default_nettype none
package tsdma_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTL = 8'h00;
  localparam logic [7:0] OFF_CUR_BASE = 8'h04;
  localparam logic [7:0] OFF_CUR_CNT = 8'h08;
  localparam logic [7:0] OFF_CUR_SIZE = 8'h0C;
  localparam logic [7:0] OFF_SB_BASE = 8'h10;
  localparam logic [7:0] OFF_SB_SIZE = 8'h14;
  localparam logic [7:0] OFF_STAT = 8'h18;
  localparam logic [7:0] OFF_MASK = 8'h1C;
  // Control register field layout
  localparam int unsigned EN_BIT = 0;
  localparam int unsigned TMO_LSB = 1;
  localparam int unsigned TMO_W = 10;
  localparam int unsigned BURST_LSB = 11;
  localparam int unsigned BURST_W = 10;
  localparam int unsigned SWAP_BIT = 21;
  localparam int unsigned DONE_BIT = 22;
  localparam int unsigned OVF_BIT = 23;
  // Capacity register field layout
  localparam int unsigned SIZE_W = 30;
  localparam int unsigned VALID_BIT = 30;
  // Reset values
  localparam logic [BURST_W-1:0] BURST_RST = 10'h010;
  localparam logic [TMO_W-1:0] TMO_RST = 10'h00A;
  // Interrupt status and mask layout
  localparam int unsigned EV_ACQ = 0;
  localparam int unsigned EV_DONE = 1;
  localparam int unsigned EV_OVF = 2;
  localparam int unsigned EV_W = 3;
  // One timestamp is one 32-bit word in memory
  localparam logic [31:0] TS_BYTES = 32'h00000004;
  localparam int unsigned OUT_W = 16;
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic last;
  } tsdma_mem_req_t;

  typedef enum logic [1:0] {
    WP_EMPTY = 2'b01,
    WP_BUSY = 2'b10
  } tsdma_wp_state_t;
endpackage : tsdma_pkg
`default_nettype wire

/* logic/tsdma_top.sv */
// Timestamp double-buffer DMA engine with AXI4-Lite register bank
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Enable set and current buffer valid: timestamps stored sequentially, else off.
// - Ten-bit coalescing timeout in milliseconds, control bits 10 to 1, read/write.
// - Ten-bit burst length in control bits 20 to 11, default sixteen.
// - Writing one to swap bit 21 makes next buffer current; zero does nothing.
// - After a software swap, completion bit 22 reads one once old buffer writes all reached memory.
// - Both buffers full sets overflow bit 23 and drops new timestamps.
// - Current start is a 32-bit writable byte address from memory start.
// - Read-only 32-bit count of samples stored in current buffer.
// - Current capacity is a 30-bit writable sample count in bits 29 to 0.
// - Valid bit 30 marks a buffer ready; no acquisition into invalid buffer.
// - Next buffer has own start and capacity/valid registers used at swap.
// - Drive a level acquisition-ready interrupt request toward the controller.
module tsdma_top
  import tsdma_pkg::*;
#(
  parameter int unsigned CYC_PER_MS_P = CYC_PER_MS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ts_valid,
  input wire logic [31:0] ts_data,
  output logic ts_ready,
  output logic mem_valid,
  input wire logic mem_ready,
  output tsdma_mem_req_t mem_req,
  input wire logic mem_ack,
  output logic channel_acq_ready_irq
);

  logic aw_have_ff, w_have_ff, bvalid_ff, rvalid_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] wd_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic en_ff, done_ff, ovf_ff, armed_ff, unrep_ff;
  logic [TMO_W-1:0] tmo_ff, ms_elapsed_ff;
  logic [BURST_W-1:0] burst_ff, beat_ff;
  logic [31:0] cur_base_ff, sb_base_ff, count_ff, ms_cyc_ff;
  logic [SIZE_W-1:0] cur_size_ff, sb_size_ff;
  logic cur_valid_ff, sb_valid_ff;
  logic [OUT_W-1:0] outst_ff, old_left_ff;
  logic [EV_W-1:0] stat_ff, mask_ff, ev;
  tsdma_wp_state_t wp_state_ff;
  tsdma_mem_req_t req_ff;

  logic [31:0] wmask, ctl_rd, ctl_wd, rd_mux;
  logic wr_fire, rd_fire, wr_hit, rd_hit;
  logic wr_ctl, wr_cur_base, wr_cur_size, wr_sb_base, wr_sb_size, wr_mask;
  logic swap_req, auto_swap, do_swap, cur_full, can_store, slot_free, store;
  logic ovf_set, done_set, acq_ev, ms_wrap, burst_last;
  logic [31:0] count_inc;
  logic [BURST_W-1:0] beat_inc;

  // Byte-lane write mask from the strobes
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign wmask[gi*8 +: 8] = {8{wstrb_ff[gi]}};
    end
  endgenerate

  // Bus handshakes; address and data are taken in either order
  assign s_axi_awready = !aw_have_ff && !bvalid_ff;
  assign s_axi_wready = !w_have_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign wr_fire = aw_have_ff && w_have_ff && !bvalid_ff;
  assign rd_fire = s_axi_arvalid && !rvalid_ff;

  // Write address decode
  assign wr_ctl = wr_fire && (aw_addr_ff == OFF_CTL);
  assign wr_cur_base = wr_fire && (aw_addr_ff == OFF_CUR_BASE);
  assign wr_cur_size = wr_fire && (aw_addr_ff == OFF_CUR_SIZE);
  assign wr_sb_base = wr_fire && (aw_addr_ff == OFF_SB_BASE);
  assign wr_sb_size = wr_fire && (aw_addr_ff == OFF_SB_SIZE);
  assign wr_mask = wr_fire && (aw_addr_ff == OFF_MASK);
  assign wr_hit = wr_ctl || wr_cur_base || wr_cur_size || wr_sb_base
                  || wr_sb_size || wr_mask || (aw_addr_ff == OFF_CUR_CNT)
                  || (aw_addr_ff == OFF_STAT);

  // Control readback; swap bit always reads zero
  always_comb begin
    ctl_rd = 32'h00000000;
    ctl_rd[EN_BIT] = en_ff;
    ctl_rd[TMO_LSB +: TMO_W] = tmo_ff;
    ctl_rd[BURST_LSB +: BURST_W] = burst_ff;
    ctl_rd[DONE_BIT] = done_ff;
    ctl_rd[OVF_BIT] = ovf_ff;
  end
  assign ctl_wd = (ctl_rd & ~wmask) | (wd_ff & wmask);
  // Only a written one in an enabled lane swaps
  assign swap_req = wr_ctl && wd_ff[SWAP_BIT] && wmask[SWAP_BIT];

  // Bus write channel capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      wd_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_ff <= 1'b1;
        aw_addr_ff <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_ff <= 1'b1;
        wd_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Read data mux; unmapped addresses read zero with an error response
  always_comb begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      OFF_CTL: rd_mux = ctl_rd;
      OFF_CUR_BASE: rd_mux = cur_base_ff;
      OFF_CUR_CNT: rd_mux = count_ff;
      OFF_CUR_SIZE: rd_mux = {1'b0, cur_valid_ff, cur_size_ff};
      OFF_SB_BASE: rd_mux = sb_base_ff;
      OFF_SB_SIZE: rd_mux = {1'b0, sb_valid_ff, sb_size_ff};
      OFF_STAT: rd_mux = {{(32-EV_W){1'b0}}, stat_ff};
      OFF_MASK: rd_mux = {{(32-EV_W){1'b0}}, mask_ff};
      default: rd_hit = 1'b0;
    endcase
  end

  // Bus read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= RESP_OKAY;
    end else if (clk_en) begin
      if (rd_fire) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_mux;
        rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // Software-owned control fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_ff <= 1'b0;
      tmo_ff <= TMO_RST;
      burst_ff <= BURST_RST;
      mask_ff <= {EV_W{1'b0}};
    end else if (clk_en) begin
      if (wr_ctl) begin
        en_ff <= ctl_wd[EN_BIT];
        tmo_ff <= ctl_wd[TMO_LSB +: TMO_W];
        burst_ff <= ctl_wd[BURST_LSB +: BURST_W];
      end
      if (wr_mask) begin
        // Merge by lane into the old mask, not into the control word
        mask_ff <= (wd_ff[EV_W-1:0] & wmask[EV_W-1:0])
                   | (mask_ff & ~wmask[EV_W-1:0]);
      end
    end
  end

  // Acquisition gating; a full current buffer advances to a valid next one
  assign cur_full = count_ff >= {2'b00, cur_size_ff};
  assign auto_swap = cur_valid_ff && cur_full && sb_valid_ff && !swap_req;
  assign do_swap = swap_req || auto_swap;
  assign can_store = en_ff && cur_valid_ff && !cur_full && !do_swap;
  assign slot_free = (wp_state_ff == WP_EMPTY) || mem_ready;
  // Timestamps that cannot be stored are taken and discarded
  assign ts_ready = can_store ? slot_free : 1'b1;
  assign store = ts_valid && can_store && slot_free;
  assign ovf_set = ts_valid && en_ff && cur_valid_ff && cur_full
                   && !sb_valid_ff;
  assign count_inc = count_ff + 32'h00000001;
  assign beat_inc = beat_ff + 10'h001;
  // Burst closes at the programmed length or at the buffer's end
  assign burst_last = (beat_inc >= burst_ff)
                      || (count_inc == {2'b00, cur_size_ff});

  // Buffer descriptors, swap and sample count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_base_ff <= 32'h00000000;
      cur_size_ff <= {SIZE_W{1'b0}};
      cur_valid_ff <= 1'b0;
      sb_base_ff <= 32'h00000000;
      sb_size_ff <= {SIZE_W{1'b0}};
      sb_valid_ff <= 1'b0;
      count_ff <= 32'h00000000;
      beat_ff <= {BURST_W{1'b0}};
    end else if (clk_en) begin
      if (wr_cur_base) begin
        cur_base_ff <= ctl_wd_sel(cur_base_ff);
      end
      if (wr_cur_size) begin
        cur_size_ff <= ctl_wd_sel({1'b0, cur_valid_ff, cur_size_ff})
                       [SIZE_W-1:0];
        cur_valid_ff <= ctl_wd_sel({1'b0, cur_valid_ff, cur_size_ff})
                        [VALID_BIT];
      end
      if (wr_sb_base) begin
        sb_base_ff <= ctl_wd_sel(sb_base_ff);
      end
      if (wr_sb_size) begin
        sb_size_ff <= ctl_wd_sel({1'b0, sb_valid_ff, sb_size_ff})
                      [SIZE_W-1:0];
        sb_valid_ff <= ctl_wd_sel({1'b0, sb_valid_ff, sb_size_ff})
                       [VALID_BIT];
      end
      // Swap wins over a same-cycle write of the current descriptor
      if (do_swap) begin
        cur_base_ff <= sb_base_ff;
        cur_size_ff <= sb_size_ff;
        cur_valid_ff <= sb_valid_ff;
        sb_valid_ff <= 1'b0;
        count_ff <= 32'h00000000;
        beat_ff <= {BURST_W{1'b0}};
      end else if (store) begin
        count_ff <= count_inc;
        beat_ff <= burst_last ? {BURST_W{1'b0}} : beat_inc;
      end
    end
  end

  // Byte-lane merge of the pending write into a register's old value
  function automatic logic [31:0] ctl_wd_sel(input logic [31:0] old);
    ctl_wd_sel = (old & ~wmask) | (wd_ff & wmask);
  endfunction : ctl_wd_sel

  // Single-word memory write stage; the address is fixed at acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp_state_ff <= WP_EMPTY;
      req_ff <= '0;
    end else if (clk_en) begin
      case (wp_state_ff)
        WP_EMPTY: begin
          if (store) begin
            wp_state_ff <= WP_BUSY;
          end
        end
        WP_BUSY: begin
          if (mem_ready && !store) begin
            wp_state_ff <= WP_EMPTY;
          end
        end
        default: wp_state_ff <= WP_EMPTY;
      endcase
      if (store) begin
        req_ff.addr <= cur_base_ff + (count_ff << 2);
        req_ff.data <= ts_data;
        req_ff.last <= burst_last;
      end
    end
  end
  assign mem_valid = (wp_state_ff == WP_BUSY);
  assign mem_req = req_ff;

  // Outstanding writes; acks return in issue order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      outst_ff <= {OUT_W{1'b0}};
      old_left_ff <= {OUT_W{1'b0}};
      armed_ff <= 1'b0;
    end else if (clk_en) begin
      outst_ff <= outst_ff + OUT_W'(store) - OUT_W'(mem_ack);
      if (swap_req) begin
        armed_ff <= 1'b1;
        old_left_ff <= outst_ff - OUT_W'(mem_ack);
      end else if (armed_ff && mem_ack && old_left_ff != {OUT_W{1'b0}}) begin
        old_left_ff <= old_left_ff - 16'h0001;
      end
      if (done_set) begin
        armed_ff <= 1'b0;
      end
    end
  end
  assign done_set = armed_ff && !swap_req
                    && (old_left_ff == {OUT_W{1'b0}});

  // Completion and overflow flags; hardware set beats write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_ff <= 1'b0;
      ovf_ff <= 1'b0;
    end else if (clk_en) begin
      if (done_set) begin
        done_ff <= 1'b1;
      end else if (swap_req || (wr_ctl && wd_ff[DONE_BIT]
                                && wmask[DONE_BIT])) begin
        done_ff <= 1'b0;
      end
      if (ovf_set) begin
        ovf_ff <= 1'b1;
      end else if (wr_ctl && wd_ff[OVF_BIT] && wmask[OVF_BIT]) begin
        ovf_ff <= 1'b0;
      end
    end
  end

  // Coalescing timer runs only while stored samples are unreported
  assign ms_wrap = (ms_cyc_ff == CYC_PER_MS_P - 1);
  assign acq_ev = unrep_ff && (ms_elapsed_ff >= tmo_ff);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unrep_ff <= 1'b0;
      ms_cyc_ff <= 32'h00000000;
      ms_elapsed_ff <= {TMO_W{1'b0}};
    end else if (clk_en) begin
      if (acq_ev || !unrep_ff) begin
        ms_cyc_ff <= 32'h00000000;
        ms_elapsed_ff <= {TMO_W{1'b0}};
      end else if (ms_wrap) begin
        ms_cyc_ff <= 32'h00000000;
        ms_elapsed_ff <= ms_elapsed_ff + 10'h001;
      end else begin
        ms_cyc_ff <= ms_cyc_ff + 32'h00000001;
      end
      // A sample in the reporting cycle stays pending
      if (store) begin
        unrep_ff <= 1'b1;
      end else if (acq_ev) begin
        unrep_ff <= 1'b0;
      end
    end
  end

  // Sticky status cleared by reading it; new events win over the clear
  always_comb begin
    ev = {EV_W{1'b0}};
    ev[EV_ACQ] = acq_ev;
    ev[EV_DONE] = done_set;
    ev[EV_OVF] = ovf_set;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_ff <= {EV_W{1'b0}};
    end else if (clk_en) begin
      if (rd_fire && ({s_axi_araddr[7:2], 2'b00} == OFF_STAT)) begin
        stat_ff <= ev;
      end else begin
        stat_ff <= stat_ff | ev;
      end
    end
  end
  assign channel_acq_ready_irq = |(stat_ff & mask_ff);

endmodule : tsdma_top
`default_nettype wire

/* tb/tsdma_assertions.sv */
// Checker of bus, memory and ready timing for the engine
`timescale 1ns/100ps
`default_nettype none
module tsdma_checker
  import tsdma_pkg::*;
#(
  parameter int unsigned CYC_PER_MS_P = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ts_ready,
  input wire logic mem_valid,
  input wire logic mem_ready,
  input wire tsdma_mem_req_t mem_req,
  input wire logic channel_acq_ready_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Write taken whole in one cycle, answered two edges on
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wr_answer;
    ##2 s_axi_bvalid;
  endsequence
  wr_resp_a: assert property (wr_taken |-> wr_answer)
    else $error("write response not on time");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response not on time");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  busy_gate_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  // A stalled word must not change under the memory
  mem_hold_a: assert property (mem_valid && !mem_ready |=>
    mem_valid && $stable(mem_req))
    else $error("memory word changed while stalled");
  ts_stall_a: assert property (!ts_ready |-> mem_valid && !mem_ready)
    else $error("timestamp refused without stall");
  quiet_start_a: assert property ($rose(aresetn) |->
    !mem_valid && !channel_acq_ready_irq && !s_axi_bvalid)
    else $error("outputs busy after reset");
endmodule : tsdma_checker
bind tsdma_top tsdma_checker #(.CYC_PER_MS_P(CYC_PER_MS_P)) chk_u (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .ts_ready(ts_ready), .mem_valid(mem_valid), .mem_ready(mem_ready),
  .mem_req(mem_req), .channel_acq_ready_irq(channel_acq_ready_irq));
`default_nettype wire

/* tb/tsdma_mem_model.sv */
// Memory write port model, prompt or stalling
`timescale 1ns/100ps
`default_nettype none
module tsdma_mem_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  input wire logic mem_valid,
  output logic mem_ready,
  output logic mem_ack
);
  logic [2:0] ack_pipe_ff;
  logic toggle_ff;
  // Slow mode stalls every other cycle to stretch handshakes
  always_ff @(posedge aclk) begin
    toggle_ff <= aresetn && !toggle_ff;
  end
  assign mem_ready = !slow || toggle_ff;
  // Commit three cycles after acceptance, in order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_pipe_ff <= 3'h0;
    end else begin
      ack_pipe_ff <= {ack_pipe_ff[1:0], mem_valid && mem_ready};
    end
  end
  assign mem_ack = ack_pipe_ff[2];
endmodule : tsdma_mem_model
`default_nettype wire

/* tb/tsdma_top_tb.sv */
// Self-checking bench for the timestamp double-buffer engine
`timescale 1ns/100ps
`default_nettype none
module tsdma_top_tb;
  import tsdma_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awa = 8'h00;
  logic [7:0] ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] tsd = 32'h0;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic br = 1'b0;
  logic arv = 1'b0;
  logic rr = 1'b0;
  logic tsv = 1'b0;
  logic slow = 1'b0;
  logic awr, wr, bv, arr, rv, tsr, memv, memr, ack, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rd;
  tsdma_mem_req_t mreq;
  int mismatches = 0;
  int checks = 0;
  logic [64:0] mq[$];
  always #4 aclk = !aclk;
  tsdma_top #(.CYC_PER_MS_P(10)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .ts_valid(tsv),
    .ts_data(tsd), .ts_ready(tsr), .mem_valid(memv),
    .mem_ready(memr), .mem_req(mreq), .mem_ack(ack),
    .channel_acq_ready_irq(irq));
  tsdma_mem_model mem_u (.aclk(aclk), .aresetn(aresetn), .slow(slow),
    .mem_valid(memv), .mem_ready(memr), .mem_ack(ack));
  // Log every word the memory accepts
  always @(posedge aclk) begin
    if (memv && memr) begin
      mq.push_back({mreq.last, mreq.addr, mreq.data});
    end
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // A wait that ran out ends the run as a failure
  task automatic lim(input int n);
    if (n >= 200) begin
      chk("wait", 32'h0, 32'h1);
      wrap_up();
    end
  endtask : lim
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
    int n;
    logic aw_done;
    logic w_done;
    n = 0;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    // Each channel released only at its own handshake
    do begin
      @(posedge aclk);
      n++;
      if (!aw_done && awr) begin
        aw_done = 1'b1;
        awv <= 1'b0;
      end
      if (!w_done && wr) begin
        w_done = 1'b1;
        wv <= 1'b0;
      end
    end while (!bv && n < 200);
    lim(n);
    br <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arv && arr) begin
        arv <= 1'b0;
      end
    end while (!rv && n < 200);
    lim(n);
    rr <= 1'b0;
    d = rd;
  endtask : rd_reg
  task automatic rd_chk(input string nm, input logic [7:0] a,
      input logic [31:0] e);
    logic [31:0] d;
    rd_reg(a, d);
    chk(nm, e, d);
  endtask : rd_chk
  task automatic send_ts(input logic [31:0] v);
    int n;
    n = 0;
    @(posedge aclk);
    tsv <= 1'b1;
    tsd <= v;
    do begin
      @(posedge aclk);
      n++;
    end while (!tsr && n < 200);
    lim(n);
    tsv <= 1'b0;
  endtask : send_ts
  // Settle past the one-cycle store latency, then count words
  task automatic words(input string nm, input int k);
    int n;
    n = 0;
    while (mq.size() < k && n < 200) begin
      @(posedge aclk);
      n++;
    end
    repeat (5) @(posedge aclk);
    chk(nm, 32'(k), 32'(mq.size()));
  endtask : words
  // Reset values, field widths, read-only and unmapped places
  task automatic t_regs;
    logic [31:0] d;
    rd_chk("ctrl", OFF_CTL, 32'h00008014);
    wr_reg(OFF_CTL, 32'h001FFFFE, RESP_OKAY);
    rd_chk("fields", OFF_CTL, 32'h001FFFFE);
    wr_reg(OFF_CUR_CNT, 32'h00000005, RESP_OKAY);
    rd_chk("count ro", OFF_CUR_CNT, 32'h0);
    wr_reg(OFF_CUR_BASE, 32'hFFFFFFFC, RESP_OKAY);
    rd_chk("cur base", OFF_CUR_BASE, 32'hFFFFFFFC);
    wr_reg(OFF_CUR_SIZE, 32'h3FFFFFFF, RESP_OKAY);
    rd_chk("cur size", OFF_CUR_SIZE, 32'h3FFFFFFF);
    wr_reg(8'h20, 32'h1, RESP_SLVERR);
    rd_reg(8'h20, d);
    chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, rresp});
    chk("unmapped", 32'h0, d);
  endtask : t_regs
  // Invalid buffer, disabled engine, then fill both and overflow
  task automatic t_acq;
    wr_reg(OFF_CUR_BASE, 32'h00000100, RESP_OKAY);
    wr_reg(OFF_CUR_SIZE, 32'h00000004, RESP_OKAY);
    wr_reg(OFF_CTL, 32'h00008015, RESP_OKAY);
    send_ts(32'h0000AAAA);
    words("invalid drop", 0);
    wr_reg(OFF_CTL, 32'h00008014, RESP_OKAY);
    wr_reg(OFF_CUR_SIZE, 32'h40000004, RESP_OKAY);
    send_ts(32'h0000BBBB);
    words("off drop", 0);
    wr_reg(OFF_SB_BASE, 32'h00000200, RESP_OKAY);
    wr_reg(OFF_SB_SIZE, 32'h40000002, RESP_OKAY);
    slow <= 1'b1;
    wr_reg(OFF_CTL, 32'h00008015, RESP_OKAY);
    for (int i = 0; i < 7; i++) begin
      send_ts(32'h00001000 + i);
    end
    words("stored", 6);
    for (int i = 0; i < 6; i++) begin
      chk("addr", 32'((i < 4) ? 'h100 + 4*i : 'h1F0 + 4*i), mq[i][63:32]);
      chk("data", 32'h00001000 + i, mq[i][31:0]);
      chk("last", 32'((i == 3) || (i == 5)), 32'(mq[i][64]));
    end
    rd_chk("ovf", OFF_CTL, 32'h00808015);
    rd_chk("count", OFF_CUR_CNT, 32'h00000002);
    rd_chk("auto base", OFF_CUR_BASE, 32'h00000200);
    rd_chk("next vld", OFF_SB_SIZE, 32'h00000002);
    wr_reg(OFF_CTL, 32'h00808015, RESP_OKAY);
    rd_chk("ovf clr", OFF_CTL, 32'h00008015);
  endtask : t_acq
  // Software swap: ignored on zero, then commit and restart
  task automatic t_swap;
    logic [31:0] d;
    int n;
    // Grow the full current buffer so a valid next one does not auto-swap
    wr_reg(OFF_CUR_SIZE, 32'h40000004, RESP_OKAY);
    wr_reg(OFF_SB_BASE, 32'h00000300, RESP_OKAY);
    wr_reg(OFF_SB_SIZE, 32'h40000008, RESP_OKAY);
    wr_reg(OFF_CTL, 32'h00008015, RESP_OKAY);
    rd_chk("no swap", OFF_CUR_BASE, 32'h00000200);
    wr_reg(OFF_CTL, 32'h00208015, RESP_OKAY);
    n = 0;
    do begin
      rd_reg(OFF_CTL, d);
      n++;
    end while (d[DONE_BIT] !== 1'b1 && n < 199);
    chk("done", 32'h00408015, d);
    rd_chk("new base", OFF_CUR_BASE, 32'h00000300);
    rd_chk("restart", OFF_CUR_CNT, 32'h0);
    rd_chk("next clr", OFF_SB_SIZE, 32'h00000008);
    mq.delete();
    send_ts(32'h00002222);
    words("swap word", 1);
    chk("swap addr", 32'h00000300, mq[0][63:32]);
    wr_reg(OFF_CTL, 32'h00408015, RESP_OKAY);
    rd_chk("done clr", OFF_CTL, 32'h00008015);
  endtask : t_swap
  // Timeout event held back by mask, raised, cleared by read
  task automatic t_irq;
    logic [31:0] d;
    rd_reg(OFF_STAT, d);
    wr_reg(OFF_CTL, 32'h00008003, RESP_OKAY);
    send_ts(32'h00003333);
    repeat (40) @(posedge aclk);
    chk("masked", 32'h0, {31'h0, irq});
    wr_reg(OFF_MASK, 32'h00000001, RESP_OKAY);
    chk("irq", 32'h1, {31'h0, irq});
    rd_chk("status", OFF_STAT, 32'h00000001);
    chk("irq clr", 32'h0, {31'h0, irq});
  endtask : t_irq
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_acq();
    t_swap();
    t_irq();
    wrap_up();
  end
endmodule : tsdma_top_tb
`default_nettype wire
